// ### src/spwm_master.sv
`timescale 1ns/1ps
`include "spwm_params.svh"

module spwm_master
  import spwm_pkg::*;
#(
  // Device-type code; arbitrary default
  parameter logic [3:0] DEV_TYPE = `SPWM_DEV_TYPE_DFLT
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial clock line, open drain
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  // Serial data line, open drain
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);

  spwm_state_t state_q;
  logic [1:0] phase_q;
  logic [3:0] bitcnt_q;
  logic byte_q;
  logic [7:0] sh_q;
  logic ackbit_q;
  logic [7:0] rx_q;
  logic nack_q;
  logic go_q;
  logic rw_q;
  logic fast_q;
  logic [2:0] sel_q;
  logic [7:0] tx_q;
  logic tick;
  logic scl_s;
  logic sda_s;
  logic busy;
  logic rd_data;
  logic aw_have_q;
  logic w_have_q;
  logic [3:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic do_write;
  logic wr_ok;
  logic launch;
  logic nack_set;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and quarter-period timebase

  spwm_sync #(.W(2)) u_sync
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({scl_i, sda_i}),
    .sync_out({scl_s, sda_s})
  );

  // Rate steps the serial clock; the device copes with both
  spwm_tick u_tick
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .fast(fast_q),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
  assign busy = go_q || (state_q != ST_IDLE);
  assign wr_ok = (aw_addr_q == `SPWM_REG_CTRL) || (aw_addr_q == `SPWM_REG_TXDATA)
    || (aw_addr_q == `SPWM_REG_STATUS);

  // Address and data are held independently, so either may come first
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      if (aw_take)
        aw_addr_q <= s_axi_awaddr;
      if (w_take)
      begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      aw_have_q <= (aw_have_q || aw_take) && !do_write;
      w_have_q <= (w_have_q || w_take) && !do_write;
      s_axi_awready <= !((aw_have_q || aw_take) && !do_write);
      s_axi_wready <= !((w_have_q || w_take) && !do_write);
    end
  end

  // Write response one cycle after both halves are held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SPWM_RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? `SPWM_RESP_OKAY : `SPWM_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Settings are frozen while a transfer runs so the bytes on the wire stay coherent
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rw_q <= 1'b0;
      fast_q <= 1'b0;
      sel_q <= `SPWM_SEL_RST;
      tx_q <= `SPWM_TXDATA_RST;
    end
    else if (do_write && w_strb_q[0] && !busy)
    begin
      if (aw_addr_q == `SPWM_REG_CTRL)
      begin
        rw_q <= w_data_q[`SPWM_CTRL_RW];
        fast_q <= w_data_q[`SPWM_CTRL_FAST];
        sel_q <= w_data_q[`SPWM_CTRL_SEL_LSB +: 3];
      end
      if (aw_addr_q == `SPWM_REG_TXDATA)
        tx_q <= w_data_q[7:0];
    end
  end

  // Go request; launch only on an idle bus
  assign launch = (state_q == ST_IDLE) && go_q && tick && scl_s && sda_s;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      go_q <= 1'b0;
    else if (launch)
      go_q <= 1'b0;
    else if (do_write && w_strb_q[0] && !busy && (aw_addr_q == `SPWM_REG_CTRL))
      go_q <= w_data_q[`SPWM_CTRL_GO];
  end

  // Read path: data registered with the valid
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `SPWM_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !(ar_take || (s_axi_rvalid && !s_axi_rready));
      if (ar_take)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `SPWM_RESP_OKAY;
        case (s_axi_araddr)
          `SPWM_REG_CTRL: s_axi_rdata <= {25'h0, sel_q, 1'b0, fast_q, rw_q, go_q};
          `SPWM_REG_TXDATA: s_axi_rdata <= {24'h0, tx_q};
          `SPWM_REG_STATUS: s_axi_rdata <= {16'h0, rx_q, 6'h0, nack_q, busy};
          default:
          begin
            s_axi_rdata <= '0;
            s_axi_rresp <= `SPWM_RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial bit engine: four quarters per bit, edges of scl at quarters 0 and 2

  assign rd_data = byte_q && rw_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= ST_IDLE;
      phase_q <= 2'h0;
      bitcnt_q <= 4'h0;
      byte_q <= 1'b0;
      sh_q <= 8'h00;
      ackbit_q <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end
    else if (tick)
    begin
      case (state_q)
        ST_IDLE:
        begin
          phase_q <= 2'h0;
          if (launch)
          begin
            state_q <= ST_START;
            sh_q <= {DEV_TYPE, sel_q, rw_q};
          end
        end
        ST_START:
        begin
          phase_q <= phase_q + 2'h1;
          if (phase_q == 2'h0)
            sda_oe <= 1'b1;
          if (phase_q == 2'h2)
            scl_oe <= 1'b1;
          if (phase_q == 2'h3)
          begin
            state_q <= ST_SHIFT;
            bitcnt_q <= 4'h0;
            byte_q <= 1'b0;
            sda_oe <= !sh_q[7];
          end
        end
        ST_SHIFT:
        begin
          phase_q <= phase_q + 2'h1;
          case (phase_q)
            2'h0: scl_oe <= 1'b0;
            2'h1:
            begin
              if (bitcnt_q == 4'h8)
                ackbit_q <= sda_s;
              else
                sh_q <= {sh_q[6:0], sda_s};
            end
            2'h2: scl_oe <= 1'b1;
            default:
            begin
              // Data only moves here, with scl already low
              if (bitcnt_q == 4'h7)
              begin
                bitcnt_q <= 4'h8;
                sda_oe <= 1'b0;
              end
              else if (bitcnt_q < 4'h7)
              begin
                bitcnt_q <= bitcnt_q + 4'h1;
                sda_oe <= rd_data ? 1'b0 : !sh_q[7];
              end
              else if (!byte_q && !ackbit_q)
              begin
                byte_q <= 1'b1;
                bitcnt_q <= 4'h0;
                sh_q <= tx_q;
                sda_oe <= rw_q ? 1'b0 : !tx_q[7];
              end
              else
              begin
                // One data byte per order; a refused byte also ends it
                state_q <= ST_STOP;
                sda_oe <= 1'b1;
              end
            end
          endcase
        end
        ST_STOP:
        begin
          phase_q <= phase_q + 2'h1;
          if (phase_q == 2'h0)
            scl_oe <= 1'b0;
          if (phase_q == 2'h2)
            sda_oe <= 1'b0;
          if (phase_q == 2'h3)
            state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Both lines are pulled low only; the high level comes from the pull-up
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
    else
    begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Received byte and refusal flag

  assign nack_set = tick && (state_q == ST_SHIFT) && (phase_q == 2'h1) && (bitcnt_q == 4'h8)
    && !rd_data && sda_s;

  // Read byte captured at the end of its eighth bit
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rx_q <= 8'h00;
    else if (tick && (state_q == ST_SHIFT) && (phase_q == 2'h3) && (bitcnt_q == 4'h7) && rd_data)
      rx_q <= sh_q;
  end

  // Sticky; a refusal in the same cycle as the clear wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      nack_q <= 1'b0;
    else if (nack_set)
      nack_q <= 1'b1;
    else if (do_write && w_strb_q[0] && (aw_addr_q == `SPWM_REG_STATUS)
      && w_data_q[`SPWM_STAT_NACK])
      nack_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_IDLE_BUS: assert property (
    (state_q == ST_START) && ($past(state_q) == ST_IDLE) |-> $past(scl_s) && $past(sda_s))
    else $error("transfer began on a busy bus");

  AST_START_EDGE: assert property (
    (state_q == ST_START) && $rose(sda_oe) |-> !scl_oe)
    else $error("start edge not made with scl high");

  AST_SDA_STABLE: assert property (
    (state_q == ST_SHIFT) && !scl_oe && $past(!scl_oe) |-> $stable(sda_oe))
    else $error("data moved while scl high");

  AST_MSB_FIRST: assert property (
    (state_q == ST_SHIFT) && !byte_q && (bitcnt_q == 4'h0) && (phase_q == 2'h2)
    |-> sda_oe == !DEV_TYPE[3])
    else $error("command byte not sent msb first");

  AST_RW_BIT: assert property (
    (state_q == ST_SHIFT) && !byte_q && (bitcnt_q == 4'h7) && (phase_q == 2'h2)
    |-> sda_oe == !rw_q)
    else $error("direction bit wrong");

  AST_ACK_RELEASE: assert property (
    (state_q == ST_SHIFT) && (bitcnt_q == 4'h8) |-> !sda_oe)
    else $error("master drove data in acknowledge slot");

  AST_NINE_CLOCKS: assert property (
    (state_q == ST_SHIFT) && $rose(byte_q) |-> $past(bitcnt_q) == 4'h8)
    else $error("byte ended before ninth clock");

  AST_STOP_END: assert property (
    (state_q == ST_IDLE) && ($past(state_q) == ST_STOP) |-> !sda_oe && !scl_oe)
    else $error("stop left a line driven");

  AST_STOP_EDGE: assert property (
    (state_q == ST_STOP) && $fell(sda_oe) |-> !scl_oe ##1 !sda_oe [*2])
    else $error("stop edge not made with scl high");

  AST_NACK_STICKY: assert property (
    nack_set |=> nack_q)
    else $error("refusal not flagged");

  AST_B_HOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");

endmodule

// ### src/spwm_params.svh
`ifndef SPWM_PARAMS_SVH
`define SPWM_PARAMS_SVH

// System clock period, 40 MHz
`define SPWM_CLK_NS 25
// Quarter of one serial clock period, regular (100 kHz) and fast (400 kHz) rate
`define SPWM_STD_QTR_NS 2500
`define SPWM_FAST_QTR_NS 625
`define SPWM_STD_QTR_CYC (`SPWM_STD_QTR_NS / `SPWM_CLK_NS)
`define SPWM_FAST_QTR_CYC (`SPWM_FAST_QTR_NS / `SPWM_CLK_NS)
`define SPWM_QTR_W 7

// Register offsets (byte addresses)
`define SPWM_REG_CTRL 4'h0
`define SPWM_REG_TXDATA 4'h4
`define SPWM_REG_STATUS 4'h8

// Control register fields
`define SPWM_CTRL_GO 0
`define SPWM_CTRL_RW 1
`define SPWM_CTRL_FAST 2
`define SPWM_CTRL_SEL_LSB 4

// Status register fields
`define SPWM_STAT_BUSY 0
`define SPWM_STAT_NACK 1
`define SPWM_STAT_RX_LSB 8

// Reset values: data byte defaults to half-scale duty code
`define SPWM_TXDATA_RST 8'h10
`define SPWM_SEL_RST 3'h0

// Device-type code in the command byte; arbitrary default, set to match the part
`define SPWM_DEV_TYPE_DFLT 4'hA

// AXI response codes
`define SPWM_RESP_OKAY 2'h0
`define SPWM_RESP_SLVERR 2'h2

`endif

// ### src/spwm_pkg.sv
package spwm_pkg;

  // Bit engine states, one-hot
  typedef enum logic [3:0]
  {
    ST_IDLE  = 4'h1,
    ST_START = 4'h2,
    ST_SHIFT = 4'h4,
    ST_STOP  = 4'h8
  } spwm_state_t;

endpackage

// ### src/spwm_sync.sv
`timescale 1ns/1ps

module spwm_sync
  import spwm_pkg::*;
#(
  parameter int W = 2
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Asynchronous in, synchronised out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  // Two flops per bit; reset high because an idle open-drain line floats high
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic meta_q;
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          meta_q <= 1'b1;
          sync_out[i] <= 1'b1;
        end
        else
        begin
          meta_q <= async_in[i];
          sync_out[i] <= meta_q;
        end
      end
    end
  endgenerate

endmodule

// ### src/spwm_tick.sv
`timescale 1ns/1ps
`include "spwm_params.svh"

module spwm_tick
  import spwm_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Rate select: 1 = fast rate
  input wire logic fast,
  // One-cycle pulse every quarter serial period
  output logic tick
);

  logic [`SPWM_QTR_W-1:0] cnt_q;

  // Down counter; reload picks the rate, so a rate change applies at the next quarter
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q <= '0;
      tick <= 1'b0;
    end
    else if (cnt_q == '0)
    begin
      cnt_q <= fast ? `SPWM_QTR_W'(`SPWM_FAST_QTR_CYC - 1) : `SPWM_QTR_W'(`SPWM_STD_QTR_CYC - 1);
      tick <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q - `SPWM_QTR_W'(1);
      tick <= 1'b0;
    end
  end

endmodule

// ### verif/spwm_dev_model.sv
`timescale 1ns/1ps
`include "spwm_params.svh"

module spwm_dev_model
#(
  parameter logic [3:0] DEV_TYPE = `SPWM_DEV_TYPE_DFLT,
  // Command codes; defaults are arbitrary
  parameter logic [2:0] CMD_SET = 3'h0,
  parameter logic [2:0] CMD_FULL = 3'h1,
  parameter logic [2:0] CMD_SHUT = 3'h2,
  parameter logic [2:0] CMD_RECALL = 3'h3
)
(
  // Wire levels
  input wire logic scl,
  input wire logic sda,
  // Select pins
  input wire logic select_pin_bit0,
  input wire logic select_pin_bit1,
  input wire logic select_pin_bit2,
  // Open-drain pull and device state
  output logic sda_pull,
  output logic [4:0] duty_q,
  output logic full_q,
  output logic shut_q,
  output logic pwm_o
);
  logic active;
  logic [7:0] rx_byte;
  logic [7:0] cfg_byte;
  logic [4:0] tick_q;

  ////////////////////////////////////////////////////////////////////////
  // Power-up state: half-scale duty, running
  initial
  begin
    sda_pull = 1'b0;
    {shut_q, full_q, duty_q} = {2'b00, 5'h10};
    active = 1'b0;
    tick_q = 5'h00;
  end

  // Data edge while clock high aborts any frame; falling edge starts anew
  always @(sda)
  begin
    if (scl === 1'b1)
    begin
      disable frame;
      sda_pull = 1'b0;
      active = !sda;
    end
  end

  task automatic get_byte(output logic [7:0] b);
    for (int i = 0; i < 8; i++)
      @(posedge scl) b = {b[6:0], sda};
  endtask

  // Ack pull stays on after the closing fall; the caller decides next level
  task automatic ack();
    @(negedge scl);
    sda_pull = 1'b1;
    @(negedge scl);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Frame engine; a stop or start disables it from outside
  initial forever
  begin
    wait (active);
    begin : frame
      get_byte(rx_byte);
      if (rx_byte[7:1] !== {DEV_TYPE, select_pin_bit2, select_pin_bit1, select_pin_bit0})
        active = 1'b0;
      else if (rx_byte[0])
      begin
        ack();
        // Snapshot first, so each bit is one bit of the byte, not a shifted word
        cfg_byte = {shut_q ? CMD_SHUT : (full_q ? CMD_FULL : CMD_SET), duty_q};
        for (int i = 7; i >= 0; i--)
        begin
          sda_pull = !cfg_byte[i];
          @(negedge scl);
        end
        sda_pull = 1'b0;
        active = 1'b0;
      end
      else
      begin
        ack();
        forever
        begin
          sda_pull = 1'b0;
          get_byte(rx_byte);
          ack();
          case (rx_byte[7:5])
            CMD_SET: {full_q, duty_q} = {1'b0, rx_byte[4:0]};
            CMD_FULL: full_q = 1'b1;
            CMD_SHUT: shut_q = 1'b1;
            CMD_RECALL: shut_q = 1'b0;
            default: ;
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // 32 ticks of 312.5 ns give the fixed 10 us period
  always #312.5 tick_q = tick_q + 5'h01;
  assign pwm_o = shut_q ? 1'bz : (full_q ? 1'b1 : (tick_q < duty_q));
endmodule

// ### verif/testbench.sv
`timescale 1ns/1ps
`include "spwm_params.svh"

`define CHECK_EQ(got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("[ERR] %0t got %h expected %h", $time, (got), (exp)); \
    end \
  end

module testbench;
  typedef struct packed
  {
    logic rw; logic fast; logic [2:0] sel; logic [7:0] data;
    logic nack; logic [7:0] rx; logic [4:0] duty; logic full; logic shut;
  } spwm_row_t;

  logic aclk, aresetn, bus_hold, b_late;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, st;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic scl_oe, sda_oe, dev_pull, dev_full, dev_shut, low_seen;
  logic scl_drv, sda_drv;
  logic [4:0] dev_duty;
  wire logic scl_line;
  wire logic sda_line;
  int err_count = 0;
  int n_tests = 0;
  spwm_row_t rows [10];

  // Open-drain wires with pull-ups
  assign scl_line = scl_oe ? 1'b0 : 1'b1;
  assign sda_line = (sda_oe || dev_pull || bus_hold) ? 1'b0 : 1'b1;

  spwm_master spwm_master_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .scl_i(scl_line),
    .scl_o(scl_drv), .scl_oe(scl_oe), .sda_i(sda_line), .sda_o(sda_drv), .sda_oe(sda_oe));

  spwm_dev_model spwm_dev_model_inst (.scl(scl_line), .sda(sda_line), .select_pin_bit0(1'b1),
    .select_pin_bit1(1'b1), .select_pin_bit2(1'b0), .sda_pull(dev_pull), .duty_q(dev_duty),
    .full_q(dev_full), .shut_q(dev_shut), .pwm_o());

  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus tasks: both channels offered together, each dropped once taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= !b_late;
    // Own flags, since valid read in this time step still shows its old value
    while (!(aw_done && w_done))
    begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready === 1'b1)
      begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1)
      begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1)
      @(posedge aclk);
    // A late bready leaves the response waiting for one more edge
    if (b_late)
    begin
      s_axi_bready <= 1'b1;
      @(posedge aclk);
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic launch(input logic rw, input logic fast, input logic [2:0] sel,
                        input logic [7:0] d);
    axi_wr(`SPWM_REG_TXDATA, {24'h0, d}, resp);
    axi_wr(`SPWM_REG_CTRL, {25'h0, sel, 1'b0, fast, rw, 1'b1}, resp);
  endtask

  // Polling only; the watchdog cuts a hang short
  task automatic wait_idle();
    st = 32'h1;
    while (st[0] !== 1'b0)
      axi_rd(`SPWM_REG_STATUS, st, resp);
  endtask

  task automatic report_and_stop();
    $display("compares %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Twelve transfers, three at the slow rate, fit well inside this span
  initial
  begin
    repeat (90000) @(posedge aclk);
    err_count++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    {aresetn, bus_hold, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 'h0;
    s_axi_wstrb = 4'hF;
    b_late = 1'b0;
    rows = '{'{1, 0, 3, 8'h00, 0, 8'h10, 5'h10, 0, 0}, '{0, 0, 3, 8'h00, 0, 8'h00, 5'h00, 0, 0},
             '{0, 1, 3, 8'h1F, 0, 8'h00, 5'h1F, 0, 0}, '{0, 1, 3, 8'h25, 0, 8'h00, 5'h1F, 1, 0},
             '{1, 1, 3, 8'h00, 0, 8'h3F, 5'h1F, 1, 0}, '{0, 1, 3, 8'h40, 0, 8'h00, 5'h1F, 1, 1},
             '{1, 0, 3, 8'h00, 0, 8'h5F, 5'h1F, 1, 1}, '{0, 1, 3, 8'h60, 0, 8'h00, 5'h1F, 1, 0},
             '{0, 1, 5, 8'h0A, 1, 8'h00, 5'h1F, 1, 0}, '{0, 1, 3, 8'h0A, 0, 8'h00, 5'h0A, 0, 0}};
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    // Table of transfers; device state and read byte follow each one
    for (int i = 0; i < 10; i++)
    begin
      launch(rows[i].rw, rows[i].fast, rows[i].sel, rows[i].data);
      wait_idle();
      `CHECK_EQ(st[`SPWM_STAT_NACK], rows[i].nack)
      if (rows[i].rw)
        `CHECK_EQ(st[15:8], rows[i].rx)
      `CHECK_EQ({dev_duty, dev_full, dev_shut}, {rows[i].duty, rows[i].full, rows[i].shut})
      `CHECK_EQ({scl_line, sda_line}, 2'b11)
      axi_wr(`SPWM_REG_STATUS, 32'h2, resp);
      $display("row %0d done", i);
    end
    // Unmapped address is refused on both channels; the write answer must wait for bready
    b_late = 1'b1;
    axi_wr(4'hC, 32'hFFFF_FFFF, resp);
    b_late = 1'b0;
    `CHECK_EQ(resp, `SPWM_RESP_SLVERR)
    axi_rd(4'hC, st, resp);
    `CHECK_EQ({resp, st}, {`SPWM_RESP_SLVERR, 32'h0})
    $display("unmapped test done");
    // Settings written while busy must not reach the wire
    launch(1'b0, 1'b1, 3'h3, 8'h07);
    axi_rd(`SPWM_REG_STATUS, st, resp);
    `CHECK_EQ(st[`SPWM_STAT_BUSY], 1'b1)
    axi_wr(`SPWM_REG_TXDATA, 32'h1F, resp);
    wait_idle();
    `CHECK_EQ(dev_duty, 5'h07)
    $display("busy test done");
    // Data line held low by a third party: no clock until it is released
    low_seen = 1'b0;
    bus_hold <= 1'b1;
    launch(1'b0, 1'b1, 3'h3, 8'h03);
    repeat (300)
    begin
      @(posedge aclk);
      if (scl_line !== 1'b1)
        low_seen = 1'b1;
    end
    `CHECK_EQ(low_seen, 1'b0)
    bus_hold <= 1'b0;
    wait_idle();
    `CHECK_EQ(dev_duty, 5'h03)
    $display("busy bus test done");
    // Second reset in mid-run
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    `CHECK_EQ({scl_drv, sda_drv, scl_oe, sda_oe}, 4'h0)
    aresetn <= 1'b1;
    axi_rd(`SPWM_REG_TXDATA, st, resp);
    `CHECK_EQ(st, {24'h0, `SPWM_TXDATA_RST})
    axi_rd(`SPWM_REG_STATUS, st, resp);
    `CHECK_EQ(st, 32'h0)
    $display("reset test done");
    report_and_stop();
  end
endmodule
